// ===== hdrins_aux_insert.v
// Function
// R1: integrator clocks this block from the link speed clock of the aux streams.
// R2: integrator resynchronises the frame sync into the link clock domain.
// R3: each rising frame sync edge inserts the local HDR packet downstream.
// R4: at most one generated HDR packet is scheduled per video frame.
// R5: incoming HDR packets are dropped so only local values reach the transmitter.
// R6: output is a stream: 72-bit data, valid, ready, sop, eop, 11-bit channel.
// R7: pass-through input is a 72-bit stream with backpressure honoured upstream.
// R8: three header bytes supplied: type code, then version, then length.
// R9: payload from a 224-bit bundle, byte 1 lowest, top two bytes reserved.
// R10: payload byte 1 holds 3-bit transfer function code, upper five bits zero.
// R11: payload byte 2 holds 3-bit metadata descriptor kind, upper bits zero.
// R12: bytes 3-14 carry three primary x/y pairs, 16 bits, low byte first.
// R13: bytes 15-18 carry white point x then y, low byte first.
// R14: bytes 19-22 carry max then min mastering luminance, low byte first.
// R15: bytes 23-26 carry max content then max frame-average light level.
// R16: blocking control low disables filtering; HDR packets pass unchanged.
// R17: generator port valid low stops any further packet generation.
// R18: reset clears schedule and edge detector and drives output valid low.
// R19: transmitter side uses backpressure; never a partial packet on its port.
`timescale 1ns/1ps
`include "hdrins_regs.vh"

module hdrins_aux_insert #(
  parameter DATA_W     = `HDRINS_DATA_W,
  parameter CHAN_W     = `HDRINS_CHAN_W,
  parameter FIFO_DEPTH = `HDRINS_FIFO_DEPTH
) (
  input  wire                        clk,
  input  wire                        reset,
  input  wire                        frame_sync,
  input  wire                        block_ext_hdr,
  input  wire                        generator_port_valid,
  input  wire [DATA_W-1:0]           aux_in_data,
  input  wire                        aux_in_valid,
  output wire                        aux_in_ready,
  input  wire                        aux_in_sop,
  input  wire                        aux_in_eop,
  output reg  [DATA_W-1:0]           aux_out_data_r,
  output reg                         aux_out_valid_r,
  input  wire                        aux_out_ready,
  output reg                         aux_out_sop_r,
  output reg                         aux_out_eop_r,
  output reg  [CHAN_W-1:0]           aux_out_channel_r,
  input  wire [2:0]                  transfer_function_code,
  input  wire [2:0]                  metadata_descriptor_kind,
  input  wire [15:0]                 primary_x0,
  input  wire [15:0]                 primary_y0,
  input  wire [15:0]                 primary_x1,
  input  wire [15:0]                 primary_y1,
  input  wire [15:0]                 primary_x2,
  input  wire [15:0]                 primary_y2,
  input  wire [15:0]                 white_point_x,
  input  wire [15:0]                 white_point_y,
  input  wire [15:0]                 max_mastering_lum,
  input  wire [15:0]                 min_mastering_lum,
  input  wire [15:0]                 max_content_light,
  input  wire [15:0]                 max_frame_avg_light,
  output wire [7:0]                  infoframe_type_byte,
  output wire [7:0]                  infoframe_version_byte,
  output wire [7:0]                  infoframe_length_byte,
  output wire [`HDRINS_BUNDLE_W-1:0] hdr_payload_bundle,
  output wire                        insert_pending
);
  localparam FW = DATA_W + 2;

  // ==========================================================
  // arbiter states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PASS = 3'b010;
  localparam [2:0] ST_GEN  = 3'b100;

  reg  [2:0]                    state_r;
  reg  [2:0]                    state_nxt;
  reg                           fs_meta_r;
  reg                           fs_sync_r;
  reg                           fs_prev_r;
  reg                           pending_r;
  reg                           dropping_r;
  reg  [`HDRINS_BEAT_IDX_W-1:0] beat_r;
  wire                          fs_rise;
  wire                          in_take;
  wire                          is_hdr_sop;
  wire                          drop_beat;
  wire                          fifo_in_valid;
  wire                          fifo_in_ready;
  wire [FW-1:0]                 fifo_out;
  wire                          fifo_out_valid;
  wire                          fifo_out_ready;
  wire                          load;
  wire                          gen_start;
  wire                          gen_last;
  wire [DATA_W-1:0]             gen_beat;

  function is_hdr_type;
    input [DATA_W-1:0] word;
    input [7:0]        type_code;
    begin
      is_hdr_type = (word[`HDRINS_TYPE_MSB:`HDRINS_TYPE_LSB] == type_code);
    end
  endfunction

  // ==========================================================
  // frame sync edge detector
  // two stages even though the source should already be on this clock;
  // costs two cycles of insertion latency, protects against a raw vsync
  always @(posedge clk)
  begin
    if (reset)
    begin
      fs_meta_r <= 1'b0;
      fs_sync_r <= 1'b0;
      fs_prev_r <= 1'b0; // see R18
    end
    else
    begin
      fs_meta_r <= frame_sync; // see R2
      fs_sync_r <= fs_meta_r;
      fs_prev_r <= fs_sync_r;
    end
  end

  assign fs_rise = fs_sync_r & ~fs_prev_r; // see R3

  // ==========================================================
  // insertion schedule: one packet per frame
  assign gen_start      = (state_r == ST_IDLE) & pending_r;
  assign insert_pending = pending_r;

  always @(posedge clk)
  begin
    if (reset)
    begin
      pending_r <= 1'b0; // see R18
    end
    else if (~generator_port_valid)
    begin
      pending_r <= 1'b0; // see R17
    end
    else if (fs_rise)
    begin
      // a second edge before service still yields one packet
      pending_r <= 1'b1; // see R3 see R4
    end
    else if (gen_start)
    begin
      pending_r <= 1'b0; // see R4
    end
  end

  // ==========================================================
  // incoming filter: whole HDR packets are swallowed
  assign is_hdr_sop    = aux_in_valid & aux_in_sop & block_ext_hdr &
                         is_hdr_type(aux_in_data, infoframe_type_byte); // see R5 see R16
  assign drop_beat     = dropping_r | is_hdr_sop;
  assign aux_in_ready  = drop_beat | fifo_in_ready;   // see R7
  assign fifo_in_valid = aux_in_valid & ~drop_beat;
  assign in_take       = aux_in_valid & aux_in_ready;

  always @(posedge clk)
  begin
    if (reset)
    begin
      dropping_r <= 1'b0;
    end
    else if (in_take & drop_beat)
    begin
      dropping_r <= ~aux_in_eop; // see R5
    end
  end

  hdrins_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk         (clk),
    .reset       (reset),
    .in_data     ({aux_in_sop, aux_in_eop, aux_in_data}),
    .in_valid    (fifo_in_valid),
    .in_ready    (fifo_in_ready),
    .out_data_r  (fifo_out),
    .out_valid_r (fifo_out_valid),
    .out_ready   (fifo_out_ready)
  );

  hdrins_frame_builder u_builder (
    .clk                      (clk),
    .reset                    (reset),
    .transfer_function_code   (transfer_function_code),
    .metadata_descriptor_kind (metadata_descriptor_kind),
    .primary_x0               (primary_x0),
    .primary_y0               (primary_y0),
    .primary_x1               (primary_x1),
    .primary_y1               (primary_y1),
    .primary_x2               (primary_x2),
    .primary_y2               (primary_y2),
    .white_point_x            (white_point_x),
    .white_point_y            (white_point_y),
    .max_mastering_lum        (max_mastering_lum),
    .min_mastering_lum        (min_mastering_lum),
    .max_content_light        (max_content_light),
    .max_frame_avg_light      (max_frame_avg_light),
    .beat_idx                 (beat_r),
    .infoframe_type_byte      (infoframe_type_byte),
    .infoframe_version_byte   (infoframe_version_byte),
    .infoframe_length_byte    (infoframe_length_byte),
    .hdr_payload_bundle       (hdr_payload_bundle),
    .beat_data                (gen_beat)
  );

  // ==========================================================
  // output multiplexer, switching only between whole packets
  assign load           = ~aux_out_valid_r | aux_out_ready;           // see R19
  assign fifo_out_ready = (state_r == ST_PASS) & load;
  assign gen_last       = (beat_r == `HDRINS_LAST_BEAT);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        // generator wins at a boundary so the frame's packet is not starved
        if (pending_r)
        begin
          state_nxt = ST_GEN; // see R3
        end
        else if (fifo_out_valid)
        begin
          state_nxt = ST_PASS;
        end
      end
      ST_PASS:
      begin
        if (fifo_out_valid & load & fifo_out[DATA_W])
        begin
          state_nxt = ST_IDLE; // see R19
        end
      end
      ST_GEN:
      begin
        if (load & gen_last)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r           <= ST_IDLE;
      beat_r            <= {`HDRINS_BEAT_IDX_W{1'b0}};
      aux_out_valid_r   <= 1'b0; // see R18
      aux_out_data_r    <= {DATA_W{1'b0}};
      aux_out_sop_r     <= 1'b0;
      aux_out_eop_r     <= 1'b0;
      aux_out_channel_r <= `HDRINS_CHANNEL;
    end
    else
    begin
      state_r           <= state_nxt;
      aux_out_channel_r <= `HDRINS_CHANNEL; // see R6
      if ((state_r == ST_PASS) & load & fifo_out_valid)
      begin
        aux_out_valid_r <= 1'b1; // see R7
        aux_out_data_r  <= fifo_out[DATA_W-1:0];
        aux_out_eop_r   <= fifo_out[DATA_W];
        aux_out_sop_r   <= fifo_out[DATA_W+1];
      end
      else if ((state_r == ST_GEN) & load)
      begin
        aux_out_valid_r <= 1'b1; // see R3 see R6
        aux_out_data_r  <= gen_beat;
        aux_out_sop_r   <= (beat_r == {`HDRINS_BEAT_IDX_W{1'b0}});
        aux_out_eop_r   <= gen_last;
        beat_r          <= gen_last ? {`HDRINS_BEAT_IDX_W{1'b0}} : beat_r + 1'b1;
      end
      else if (load)
      begin
        aux_out_valid_r <= 1'b0;
      end
    end
  end
endmodule

// ===== hdrins_regs.vh
`ifndef HDRINS_REGS_VH
`define HDRINS_REGS_VH

// ==========================================================
// stream geometry
`define HDRINS_DATA_W        72
`define HDRINS_CHAN_W        11
`define HDRINS_FIFO_DEPTH    32
`define HDRINS_BUNDLE_W      224
`define HDRINS_BEATS         4
`define HDRINS_BEAT_IDX_W    2
`define HDRINS_LAST_BEAT     2'h3

// ==========================================================
// generated packet header and channel defaults
`define HDRINS_TYPE_CODE     8'h00
`define HDRINS_VERSION       8'h01
`define HDRINS_PAYLOAD_LEN   8'h1A
`define HDRINS_CHANNEL       11'h000
`define HDRINS_TYPE_LSB      0
`define HDRINS_TYPE_MSB      7

// ==========================================================
// payload bundle field positions
`define HDRINS_PB_TFC_LSB    0
`define HDRINS_PB_MDK_LSB    8
`define HDRINS_PB_META_LSB   16
`define HDRINS_PB_META_W     192
`define HDRINS_PB_RSVD_LSB   208
`define HDRINS_PB_RSVD_W     16

`endif

// ===== hdrins_fifo.v
`timescale 1ns/1ps

module hdrins_fifo #(
  parameter WIDTH = 74,
  parameter DEPTH = 32
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data_r,
  output reg              out_valid_r,
  input  wire             out_ready
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam CW = $clog2(DEPTH + 1);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [CW-1:0]    count_r;
  wire            wr_en;
  wire            rd_en;

  // ==========================================================
  // storage with a registered read stage
  assign in_ready = (count_r != DEPTH[CW-1:0]);
  assign wr_en    = in_valid & in_ready;
  // refill the output register whenever it empties or is taken
  assign rd_en    = (count_r != {CW{1'b0}}) & (~out_valid_r | out_ready);

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {CW{1'b0}};
      out_valid_r <= 1'b0;
      out_data_r  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_en)
      begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (rd_en)
      begin
        rd_ptr_r    <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
        out_data_r  <= mem[rd_ptr_r];
        out_valid_r <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_r <= 1'b0;
      end
      if (wr_en & ~rd_en)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (rd_en & ~wr_en)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ===== hdrins_frame_builder.v
`timescale 1ns/1ps
`include "hdrins_regs.vh"

module hdrins_frame_builder (
  input  wire                          clk,
  input  wire                          reset,
  input  wire [2:0]                    transfer_function_code,
  input  wire [2:0]                    metadata_descriptor_kind,
  input  wire [15:0]                   primary_x0,
  input  wire [15:0]                   primary_y0,
  input  wire [15:0]                   primary_x1,
  input  wire [15:0]                   primary_y1,
  input  wire [15:0]                   primary_x2,
  input  wire [15:0]                   primary_y2,
  input  wire [15:0]                   white_point_x,
  input  wire [15:0]                   white_point_y,
  input  wire [15:0]                   max_mastering_lum,
  input  wire [15:0]                   min_mastering_lum,
  input  wire [15:0]                   max_content_light,
  input  wire [15:0]                   max_frame_avg_light,
  input  wire [`HDRINS_BEAT_IDX_W-1:0] beat_idx,
  output reg  [7:0]                    infoframe_type_byte,
  output reg  [7:0]                    infoframe_version_byte,
  output reg  [7:0]                    infoframe_length_byte,
  output reg  [`HDRINS_BUNDLE_W-1:0]   hdr_payload_bundle,
  output wire [`HDRINS_DATA_W-1:0]     beat_data
);
  localparam SER_W = `HDRINS_BEATS * `HDRINS_DATA_W;

  wire [`HDRINS_PB_META_W-1:0] meta_flat;
  wire [`HDRINS_BUNDLE_W-1:0]  bundle_nxt;
  wire [SER_W-1:0]             serial;

  // ==========================================================
  // payload bundle assembly
  assign meta_flat = {max_frame_avg_light, max_content_light, min_mastering_lum,
                      max_mastering_lum, white_point_y, white_point_x, primary_y2,
                      primary_x2, primary_y1, primary_x1, primary_y0, primary_x0};

  assign bundle_nxt[`HDRINS_PB_TFC_LSB +: 8] = {5'h0_0, transfer_function_code};   // see R10
  assign bundle_nxt[`HDRINS_PB_MDK_LSB +: 8] = {5'h0_0, metadata_descriptor_kind}; // see R11
  assign bundle_nxt[`HDRINS_PB_RSVD_LSB +: `HDRINS_PB_RSVD_W] = 16'h0000;         // see R9

  // each 16-bit value goes out low byte first, two bytes per field
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1)
    begin : g_field
      assign bundle_nxt[`HDRINS_PB_META_LSB + 16*g +: 16] = meta_flat[16*g +: 16]; // see R12
    end
  endgenerate
  // fields 6..7 white point, 8..9 luminance, 10..11 light levels: see R13 see R14 see R15

  always @(posedge clk)
  begin
    if (reset)
    begin
      infoframe_type_byte    <= 8'h00;
      infoframe_version_byte <= 8'h00;
      infoframe_length_byte  <= 8'h00;
      hdr_payload_bundle     <= {`HDRINS_BUNDLE_W{1'b0}};
    end
    else
    begin
      infoframe_type_byte    <= `HDRINS_TYPE_CODE;   // see R8
      infoframe_version_byte <= `HDRINS_VERSION;     // see R8
      infoframe_length_byte  <= `HDRINS_PAYLOAD_LEN; // see R8
      hdr_payload_bundle     <= bundle_nxt;          // see R9
    end
  end

  // ==========================================================
  // beat serialiser: header bytes first, then payload, zero padded
  assign serial = {{(SER_W - 24 - `HDRINS_BUNDLE_W){1'b0}}, hdr_payload_bundle,
                   infoframe_length_byte, infoframe_version_byte, infoframe_type_byte};
  assign beat_data = serial[beat_idx * `HDRINS_DATA_W +: `HDRINS_DATA_W];
endmodule

// ===== hdrins_aux_insert_monitor.sv
`timescale 1ns/1ps
`include "hdrins_regs.vh"

// ==========================================
// port checker for the aux inserter
module hdrins_aux_insert_monitor #(
  parameter DATA_W = `HDRINS_DATA_W,
  parameter CHAN_W = `HDRINS_CHAN_W
) (
  input wire              clk,
  input wire              reset,
  input wire              frame_sync,
  input wire              block_ext_hdr,
  input wire              generator_port_valid,
  input wire [DATA_W-1:0] aux_in_data,
  input wire              aux_in_valid,
  input wire              aux_in_ready,
  input wire              aux_in_sop,
  input wire [DATA_W-1:0] aux_out_data_r,
  input wire              aux_out_valid_r,
  input wire              aux_out_ready,
  input wire              aux_out_sop_r,
  input wire              aux_out_eop_r,
  input wire [CHAN_W-1:0] aux_out_channel_r,
  input wire [2:0]        transfer_function_code,
  input wire [2:0]        metadata_descriptor_kind,
  input wire [223:0]      hdr_payload_bundle,
  input wire              insert_pending
);
  // high between an accepted sop and its eop on the transmit side
  reg in_pkt_r;
  always @(posedge clk)
    if (reset)
      in_pkt_r <= 1'b0;
    else if (aux_out_valid_r && aux_out_ready)
      in_pkt_r <= !aux_out_eop_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================
  // sequences
  sequence s_stalled; aux_out_valid_r && !aux_out_ready; endsequence
  sequence s_held; aux_out_valid_r && $stable(aux_out_data_r) && $stable(aux_out_eop_r); endsequence
  sequence s_rise; $rose(frame_sync) && generator_port_valid ##1 generator_port_valid [*3]; endsequence

  // ==========================================
  // properties
  property p_hold; s_stalled |=> s_held and $stable(aux_out_sop_r); endproperty
  a_hold: assert property (p_hold) else $error("beat changed under stall");
  property p_open; aux_out_valid_r && aux_out_sop_r |-> !in_pkt_r; endproperty
  a_open: assert property (p_open) else $error("sop inside a packet");
  property p_cont; aux_out_valid_r && !aux_out_sop_r |-> in_pkt_r; endproperty
  a_cont: assert property (p_cont) else $error("beat outside a packet");
  property p_chan; aux_out_valid_r |-> aux_out_channel_r == `HDRINS_CHANNEL; endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_rst; disable iff (1'b0) reset |=> !aux_out_valid_r && !insert_pending; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_bund; !$past(reset) |-> hdr_payload_bundle[15:0] ==
    {5'h0, $past(metadata_descriptor_kind), 5'h0, $past(transfer_function_code)}; endproperty
  a_bund: assert property (p_bund) else $error("bundle low bytes wrong");
  property p_ins; s_rise |-> ##[0:3] (insert_pending || aux_out_valid_r && aux_out_sop_r); endproperty
  a_ins: assert property (p_ins) else $error("sync edge not scheduled");
  property p_stop; !generator_port_valid [*2] |-> !insert_pending; endproperty
  a_stop: assert property (p_stop) else $error("pending while disabled");
  property p_drop; block_ext_hdr && aux_in_valid && aux_in_sop &&
    aux_in_data[7:0] == `HDRINS_TYPE_CODE |-> aux_in_ready; endproperty
  a_drop: assert property (p_drop) else $error("dropped packet refused");
endmodule

bind hdrins_aux_insert hdrins_aux_insert_monitor #(.DATA_W(DATA_W), .CHAN_W(CHAN_W)) mon (
  .clk(clk), .reset(reset), .frame_sync(frame_sync), .block_ext_hdr(block_ext_hdr),
  .generator_port_valid(generator_port_valid), .aux_in_data(aux_in_data),
  .aux_in_valid(aux_in_valid), .aux_in_ready(aux_in_ready), .aux_in_sop(aux_in_sop),
  .aux_out_data_r(aux_out_data_r), .aux_out_valid_r(aux_out_valid_r),
  .aux_out_ready(aux_out_ready), .aux_out_sop_r(aux_out_sop_r), .aux_out_eop_r(aux_out_eop_r),
  .aux_out_channel_r(aux_out_channel_r), .transfer_function_code(transfer_function_code),
  .metadata_descriptor_kind(metadata_descriptor_kind),
  .hdr_payload_bundle(hdr_payload_bundle), .insert_pending(insert_pending));

// ===== hdrins_sink_model.sv
`timescale 1ns/1ps

// ==========================================
// transmit-side aux sink that can stall
module hdrins_sink_model (
  input  wire        clk,
  input  wire        reset,
  input  wire        valid,
  input  wire [71:0] data,
  input  wire        sop,
  input  wire        eop,
  input  wire        stall,
  input  wire        slow,
  output wire        ready,
  output reg  [31:0] n_r
);
  reg [71:0] beat_d [0:127];
  reg        beat_s [0:127];
  reg        beat_e [0:127];
  reg        tog_r;

  // slow mode takes every other beat, so the source has to hold its word
  assign ready = !stall && (!slow || tog_r);
  // same link clock as the stream it takes
  always @(posedge clk)
  begin
    tog_r <= !tog_r && !reset;
    if (reset)
      n_r <= 32'h0;
    else if (valid && ready)
    begin
      beat_d[n_r[6:0]] <= data;
      beat_s[n_r[6:0]] <= sop;
      beat_e[n_r[6:0]] <= eop;
      n_r <= n_r + 32'h1;
    end
  end
endmodule

// ===== tb_hdrins_aux_insert.sv
`timescale 1ns/1ps
`include "hdrins_regs.vh"

module tb_hdrins_aux_insert;
  reg          clk = 1'b0, reset = 1'b1, fs = 1'b0, blk = 1'b1, gpv = 1'b1;
  reg          in_v = 1'b0, in_s = 1'b0, in_e = 1'b0, stall = 1'b0, slow = 1'b0;
  reg  [71:0]  in_d = 72'h0;
  reg  [2:0]   tfc = 3'h5, mdk = 3'h2;
  reg  [15:0]  f [0:11];
  wire [71:0]  o_d;
  wire [223:0] pbo;
  wire [31:0]  n;
  wire [10:0]  o_ch;
  wire [7:0]   hb_t, hb_v, hb_l;
  wire         o_v, o_s, o_e, o_rdy, in_rdy, pend;
  integer      n_mismatch = 0, compares = 0, cyc = 0, i, k, base;

  always #20 clk = ~clk;

  hdrins_aux_insert dut (
    .clk(clk), .reset(reset), .frame_sync(fs), .block_ext_hdr(blk),
    .generator_port_valid(gpv), .aux_in_data(in_d), .aux_in_valid(in_v),
    .aux_in_ready(in_rdy), .aux_in_sop(in_s), .aux_in_eop(in_e), .aux_out_data_r(o_d),
    .aux_out_valid_r(o_v), .aux_out_ready(o_rdy), .aux_out_sop_r(o_s), .aux_out_eop_r(o_e),
    .aux_out_channel_r(o_ch), .transfer_function_code(tfc), .metadata_descriptor_kind(mdk),
    .primary_x0(f[0]), .primary_y0(f[1]), .primary_x1(f[2]), .primary_y1(f[3]),
    .primary_x2(f[4]), .primary_y2(f[5]), .white_point_x(f[6]), .white_point_y(f[7]),
    .max_mastering_lum(f[8]), .min_mastering_lum(f[9]), .max_content_light(f[10]),
    .max_frame_avg_light(f[11]), .infoframe_type_byte(hb_t), .infoframe_version_byte(hb_v),
    .infoframe_length_byte(hb_l), .hdr_payload_bundle(pbo), .insert_pending(pend));

  hdrins_sink_model snk (
    .clk(clk), .reset(reset), .valid(o_v), .data(o_d), .sop(o_s), .eop(o_e),
    .stall(stall), .slow(slow), .ready(o_rdy), .n_r(n));

  // ==========================================
  // helpers
  task chk(input [223:0] e, input [223:0] g, input string nm);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0s expected %0h seen %0h", nm, e, g);
    end
  end
  endtask

  // holds the beat until ready is seen high at a falling edge, then waits for the next rising edge
  task put(input [71:0] d, input s, input e);
  begin
    in_d <= d;
    in_s <= s;
    in_e <= e;
    in_v <= 1'b1;
    @(negedge clk);
    while (in_rdy !== 1'b1)
      @(negedge clk);
    @(posedge clk);
  end
  endtask

  task drop;
  begin
    in_v <= 1'b0;
    in_d <= ~in_d;
  end
  endtask

  task waitn(input integer want);
    integer j;
  begin
    for (j = 0; j < 400 && n < want; j = j + 1)
      @(posedge clk);
  end
  endtask

  function automatic [223:0] exp_pb();
    exp_pb = {16'h0000, f[11], f[10], f[9], f[8], f[7], f[6], f[5], f[4], f[3], f[2], f[1],
              f[0], 5'h0, mdk, 5'h0, tfc};
  endfunction

  function automatic [71:0] exp_beat(input integer b);
    reg [287:0] p;
  begin
    p = {40'h0, exp_pb(), `HDRINS_PAYLOAD_LEN, `HDRINS_VERSION, `HDRINS_TYPE_CODE};
    exp_beat = p[b * 72 +: 72];
  end
  endfunction

  task close_out;
  begin
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // ==========================================
  // scenarios
  task t_reset;
  begin
    chk(0, o_v, "reset valid");
    chk(0, pend, "reset pending");
  end
  endtask

  task t_fields;
  begin
    chk({`HDRINS_TYPE_CODE, `HDRINS_VERSION, `HDRINS_PAYLOAD_LEN}, {hb_t, hb_v, hb_l}, "hdr");
    chk(exp_pb(), pbo, "bundle");
    chk(`HDRINS_CHANNEL, o_ch, "channel");
  end
  endtask

  task t_gen;
  begin
    base = n;
    slow <= 1'b1;
    fs <= 1'b1;
    waitn(base + 4);
    for (k = 0; k < 4; k = k + 1)
    begin
      chk(exp_beat(k), snk.beat_d[base + k], "gen beat");
      chk({k == 0, k == 3}, {snk.beat_s[base + k], snk.beat_e[base + k]}, "gen frame");
    end
    repeat (40) @(posedge clk);
    chk(base + 4, n, "one per frame");
    fs <= 1'b0;
    slow <= 1'b0;
  end
  endtask

  task t_nogen;
  begin
    base = n;
    gpv <= 1'b0;
    repeat (2) @(posedge clk);
    fs <= 1'b1;
    repeat (30) @(posedge clk);
    chk(0, pend, "pending off");
    fs <= 1'b0;
    gpv <= 1'b1;
    repeat (20) @(posedge clk);
    chk(base, n, "no insertion");
  end
  endtask

  task t_filt;
  begin
    base = n;
    put(72'hC300, 1'b1, 1'b0);
    put(72'h7777, 1'b0, 1'b1);
    put(72'hC305, 1'b1, 1'b1);
    drop;
    repeat (30) @(posedge clk);
    chk(base + 1, n, "filtered count");
    chk(72'hC305, snk.beat_d[base], "kept beat");
    blk <= 1'b0;
    put(72'hC300, 1'b1, 1'b0);
    put(72'h7777, 1'b0, 1'b1);
    drop;
    waitn(base + 3);
    chk({72'hC300, 72'h7777}, {snk.beat_d[base + 1], snk.beat_d[base + 2]}, "passed");
  end
  endtask

  // fills the fifo against a stalled sink, then drains through a slow one
  task t_fill;
  begin
    base = n;
    k = 0;
    stall <= 1'b1;
    in_d <= 72'h0101;
    in_s <= 1'b1;
    in_e <= 1'b0;
    in_v <= 1'b1;
    @(negedge clk);
    while (in_rdy === 1'b1 && k < 47)
    begin
      @(posedge clk);
      k = k + 1;
      in_d <= 72'h0101 + k;
      in_s <= 1'b0;
      in_e <= (k == 47);
      @(negedge clk);
    end
    chk(`HDRINS_FIFO_DEPTH + 2, k, "accepted when full");
    @(posedge clk);
    stall <= 1'b0;
    slow <= 1'b1;
    for (; k < 48; k = k + 1)
      put(72'h0101 + k, 1'b0, k == 47);
    drop;
    waitn(base + 48);
    for (k = 0; k < 48; k = k + 1)
      chk(72'h0101 + k, snk.beat_d[base + k], "drain order");
    slow <= 1'b0;
  end
  endtask

  initial
  begin
    for (i = 0; i < 12; i = i + 1)
      f[i] = 16'h8021 + 16'h0123 * i[15:0];
    repeat (2) @(posedge clk);
    t_reset;
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    t_fields;
    t_gen;
    t_nogen;
    t_filt;
    t_fill;
    close_out;
  end

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
endmodule
